// file: design/smau_map.svh
`ifndef SMAU_MAP_SVH
`define SMAU_MAP_SVH
// register byte offsets
`define SMAU_OFF_OPA 8'h00
`define SMAU_OFF_OPB 8'h04
`define SMAU_OFF_OPC 8'h08
`define SMAU_OFF_ACCLO 8'h0C
`define SMAU_OFF_ACCHI 8'h10
`define SMAU_OFF_RES 8'h14
`define SMAU_OFF_CMD 8'h18
`define SMAU_OFF_STAT 8'h1C
`define SMAU_OFF_NONE 8'hFF
// status field positions
`define SMAU_STAT_Q 0
`define SMAU_STAT_NZCV_LSB 28
// reset values
`define SMAU_RST_WORD 32'h0000_0000
`define SMAU_RST_CMD 8'h00
`define SMAU_RST_NZCV 4'h0
// rounding constant for high word ops
`define SMAU_ROUND_K 64'h0000_0000_8000_0000
`endif

// file: design/smau_pkg.sv
`default_nettype none

package smau_pkg;
    // operation codes in the command register
    typedef enum logic [3:0] {
        op_signed_long_mac = 4'h0,
        op_long_mac_half = 4'h1,
        op_dual_long_accumulate = 4'h2,
        op_dual_mult_subtract_acc32 = 4'h3,
        op_dual_mult_subtract_acc64 = 4'h4,
        op_high_word_mult_acc = 4'h5,
        op_high_word_mult_sub = 4'h6,
        op_high_word_mult = 4'h7,
        op_dual_mult_add = 4'h8,
        op_dual_mult_sub = 4'h9,
        op_half_mult = 4'hA,
        op_word_by_half_mult = 4'hB
    } smau_op_e;

    // command word, low byte
    typedef struct packed {
        logic rnd;
        logic exch;
        logic y_top;
        logic x_top;
        logic [3:0] op;
    } smau_cmd_s;

    // whole state of the unit
    typedef struct packed {
        logic [31:0] opa;
        logic [31:0] opb;
        logic [31:0] opc;
        logic [31:0] acc_lo;
        logic [31:0] acc_hi;
        logic [31:0] res;
        smau_cmd_s cmd;
        logic q;
        logic [3:0] nzcv;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic rd_pend;
        logic [7:0] rd_addr;
        logic [31:0] hrdata;
        logic hready;
    } smau_state_s;
endpackage : smau_pkg

`default_nettype wire

// file: design/smau_top.sv
// Contract
// - selector bottom takes [15:0], top [31:16]
// - signed 32x32 plus 64-bit pair, written back
// - low word bits 31..0, high word upper
// - halfword product sign-extended into 64-bit pair
// - unselected halfwords never affect results
// - dual long pairs straight or exchanged
// - dual long adds both products to pair
// - exchange swaps second operand halfwords
// - bottom minus top product plus accumulate
// - long dual subtract accumulates into pair
// - dual subtract accumulate overflow sets sticky
// - high word multiply, optional round, accumulate
// - high word subtracted from accumulate operand
// - round adds constant before taking high
// - dual multiply add writes product sum
// - dual add overflow sets sticky flag
// - dual subtract writes bottom minus top
// - halfword multiply writes full 32-bit product
// - word by half writes bits 47..16
// - condition flags untouched by operations
// - sticky flag only cleared by status write
//
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "smau_map.svh"

module smau_top #(
    parameter int DATA_W = 32
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic [DATA_W-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // status towards the core
    output logic overflow_sticky
);
    import smau_pkg::*;

    // elaboration check of the bus width
    if (DATA_W != 32) begin : g_width_chk
        $error("smau_top supports only 32-bit data");
    end

    smau_state_s s_q;
    smau_state_s s_d;
    smau_cmd_s wcmd;
    logic accept;
    logic cmd_fire;
    logic stat_wr;
    logic [15:0] a_lo;
    logic [15:0] a_hi;
    logic [15:0] b_lo;
    logic [15:0] b_hi;
    logic [15:0] a_sel;
    logic [15:0] b_sel;
    logic [15:0] bx_lo;
    logic [15:0] bx_hi;
    logic [31:0] p_sel;
    logic [31:0] p_top;
    logic [31:0] p_bot;
    logic [63:0] p_word;
    logic [47:0] p_wh;
    logic [63:0] acc;
    logic [63:0] rounded;
    logic [31:0] hiw;
    logic [32:0] diff33;
    logic [32:0] add33;
    logic [33:0] sub34;
    logic ovf_sub;
    logic ovf_add;
    logic [31:0] rd_word;

    // bus decode
    assign accept = hsel & htrans[1] & hready;
    assign cmd_fire = s_q.wr_pend && (s_q.wr_addr == `SMAU_OFF_CMD);
    assign stat_wr = s_q.wr_pend && (s_q.wr_addr == `SMAU_OFF_STAT);
    assign wcmd = hwdata[7:0];

    // operand halves
    assign a_lo = s_q.opa[15:0];
    assign a_hi = s_q.opa[31:16];
    assign b_lo = s_q.opb[15:0];
    assign b_hi = s_q.opb[31:16];

    assign a_sel = wcmd.x_top ? a_hi : a_lo;
    assign b_sel = wcmd.y_top ? b_hi : b_lo;

    assign bx_hi = wcmd.exch ? b_lo : b_hi;
    assign bx_lo = wcmd.exch ? b_hi : b_lo;

    // signed products
    assign p_sel = 32'($signed(a_sel) * $signed(b_sel));
    assign p_top = 32'($signed(a_hi) * $signed(bx_hi));
    assign p_bot = 32'($signed(a_lo) * $signed(bx_lo));
    assign p_word = 64'($signed(s_q.opa) * $signed(s_q.opb));
    assign p_wh = 48'($signed(s_q.opa) * $signed(b_sel));

    assign acc = {s_q.acc_hi, s_q.acc_lo};

    assign rounded = p_word + (wcmd.rnd ? `SMAU_ROUND_K : 64'h0);
    assign hiw = rounded[63:32];

    assign diff33 = {p_bot[31], p_bot} - {p_top[31], p_top};
    assign add33 = {p_top[31], p_top} + {p_bot[31], p_bot};
    assign sub34 = {diff33[32], diff33} + {{2{s_q.opc[31]}}, s_q.opc};

    assign ovf_sub = (sub34[33:31] != 3'h0) && (sub34[33:31] != 3'h7);
    assign ovf_add = add33[32] != add33[31];

    // register read mux
    always_comb begin
        unique case (s_q.rd_addr)
            `SMAU_OFF_OPA: rd_word = s_q.opa;
            `SMAU_OFF_OPB: rd_word = s_q.opb;
            `SMAU_OFF_OPC: rd_word = s_q.opc;
            `SMAU_OFF_ACCLO: rd_word = s_q.acc_lo;
            `SMAU_OFF_ACCHI: rd_word = s_q.acc_hi;
            `SMAU_OFF_RES: rd_word = s_q.res;
            `SMAU_OFF_CMD: rd_word = {24'h0, s_q.cmd};
            `SMAU_OFF_STAT: rd_word = {s_q.nzcv, 27'h0, s_q.q};
            default: rd_word = 32'h0;
        endcase
    end

    // next state
    always_comb begin
        s_d = s_q;
        s_d.wr_pend = 1'b0;
        // read data phase, one wait cycle
        if (s_q.rd_pend) begin
            s_d.hrdata = rd_word;
            s_d.hready = 1'b1;
            s_d.rd_pend = 1'b0;
        end
        // write data phase
        if (s_q.wr_pend) begin
            unique case (s_q.wr_addr)
                `SMAU_OFF_OPA: s_d.opa = hwdata;
                `SMAU_OFF_OPB: s_d.opb = hwdata;
                `SMAU_OFF_OPC: s_d.opc = hwdata;
                `SMAU_OFF_ACCLO: s_d.acc_lo = hwdata;
                `SMAU_OFF_ACCHI: s_d.acc_hi = hwdata;
                `SMAU_OFF_CMD: s_d.cmd = wcmd;
                `SMAU_OFF_STAT: begin
                    s_d.q = hwdata[`SMAU_STAT_Q];
                    s_d.nzcv = hwdata[`SMAU_STAT_NZCV_LSB+:4];
                end
                default: s_d.cmd = s_q.cmd;
            endcase
        end
        // operation launched by a command write
        // condition flags never written here
        if (cmd_fire) begin
            unique case (wcmd.op)
                op_signed_long_mac: begin
                    {s_d.acc_hi, s_d.acc_lo} = acc + p_word;
                end
                op_long_mac_half: begin
                    {s_d.acc_hi, s_d.acc_lo} = acc + {{32{p_sel[31]}}, p_sel};
                end
                op_dual_long_accumulate: begin
                    {s_d.acc_hi, s_d.acc_lo} = acc + {{32{p_top[31]}}, p_top}
                        + {{32{p_bot[31]}}, p_bot};
                end
                op_dual_mult_subtract_acc32: begin
                    s_d.res = sub34[31:0];
                    s_d.q = s_d.q | ovf_sub;
                end
                op_dual_mult_subtract_acc64: begin
                    {s_d.acc_hi, s_d.acc_lo} = acc + {{31{diff33[32]}}, diff33};
                end
                op_high_word_mult_acc: begin
                    s_d.res = s_q.opc + hiw;
                end
                op_high_word_mult_sub: begin
                    s_d.res = s_q.opc - hiw;
                end
                op_high_word_mult: begin
                    s_d.res = hiw;
                end
                op_dual_mult_add: begin
                    s_d.res = add33[31:0];
                    s_d.q = s_d.q | ovf_add;
                end
                op_dual_mult_sub: begin
                    s_d.res = diff33[31:0];
                end
                op_half_mult: begin
                    s_d.res = p_sel;
                end
                op_word_by_half_mult: begin
                    s_d.res = p_wh[47:16];
                end
                default: s_d.res = s_q.res;
            endcase
        end
        // address phase
        if (accept) begin
            if (hwrite) begin
                s_d.wr_pend = 1'b1;
                s_d.wr_addr = (haddr[31:8] == 24'h0) ? haddr[7:0] : `SMAU_OFF_NONE;
            end else begin
                s_d.rd_pend = 1'b1;
                s_d.rd_addr = (haddr[31:8] == 24'h0) ? haddr[7:0] : `SMAU_OFF_NONE;
                s_d.hready = 1'b0;
            end
        end
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q.opa <= `SMAU_RST_WORD;
            s_q.opb <= `SMAU_RST_WORD;
            s_q.opc <= `SMAU_RST_WORD;
            s_q.acc_lo <= `SMAU_RST_WORD;
            s_q.acc_hi <= `SMAU_RST_WORD;
            s_q.res <= `SMAU_RST_WORD;
            s_q.cmd <= `SMAU_RST_CMD;
            s_q.q <= 1'b0;
            s_q.nzcv <= `SMAU_RST_NZCV;
            s_q.wr_pend <= 1'b0;
            s_q.wr_addr <= `SMAU_OFF_NONE;
            s_q.rd_pend <= 1'b0;
            s_q.rd_addr <= `SMAU_OFF_NONE;
            s_q.hrdata <= `SMAU_RST_WORD;
            s_q.hready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs from state flops, hresp tied low
    assign hrdata = s_q.hrdata;
    assign hreadyout = s_q.hready;
    assign hresp = 1'b0; // always okay
    assign overflow_sticky = s_q.q;

    // checks on the datapath and flags
    a_half_select: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_fire && wcmd.op == op_half_mult && !wcmd.x_top && wcmd.y_top
        |=> s_q.res == 32'($signed($past(s_q.opa[15:0]))
            * $signed($past(s_q.opb[31:16]))))
        else $error("halfword selection wrong");

    a_long_mac: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_fire && wcmd.op == op_signed_long_mac
        |=> {s_q.acc_hi, s_q.acc_lo} == {$past(s_q.acc_hi), $past(s_q.acc_lo)}
            + 64'($signed($past(s_q.opa)) * $signed($past(s_q.opb))))
        else $error("long mac sum wrong");

    a_dual_exch: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_fire && wcmd.op == op_dual_long_accumulate && wcmd.exch
        |=> {s_q.acc_hi, s_q.acc_lo} == {$past(s_q.acc_hi), $past(s_q.acc_lo)}
            + 64'($signed($past(s_q.opa[31:16])) * $signed($past(s_q.opb[15:0])))
            + 64'($signed($past(s_q.opa[15:0])) * $signed($past(s_q.opb[31:16]))))
        else $error("exchanged dual accumulate wrong");

    a_word_half: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_fire && wcmd.op == op_word_by_half_mult && !wcmd.y_top
        |=> s_q.res == 32'(48'($signed($past(s_q.opa))
            * $signed($past(s_q.opb[15:0]))) >> 16))
        else $error("word by half result wrong");

    a_round_high: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_fire && wcmd.op == op_high_word_mult && wcmd.rnd
        |=> s_q.res == 32'((64'($signed($past(s_q.opa)) * $signed($past(s_q.opb)))
            + `SMAU_ROUND_K) >> 32))
        else $error("rounded high word wrong");

    a_add_ovf: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_fire && wcmd.op == op_dual_mult_add && ovf_add
        |=> s_q.q ##1 (s_q.q || $past(stat_wr)))
        else $error("dual add overflow not sticky");

    a_q_sticky: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_q.q && !stat_wr |=> s_q.q)
        else $error("sticky flag cleared without write");

    a_flags_kept: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !stat_wr |=> $stable(s_q.nzcv))
        else $error("condition flags changed");

    a_read_wait: assert property (
        @(posedge hclk) disable iff (!hresetn)
        accept && !hwrite && haddr == {24'h00_0000, `SMAU_OFF_ACCHI}
        |=> !hreadyout ##1 (hreadyout && hrdata == s_q.acc_hi))
        else $error("high word read wrong");

endmodule : smau_top

`default_nettype wire

// file: tb/smau_master.sv
`timescale 1ns/100ps
`default_nettype none

module smau_master (
    // clock
    input wire logic hclk,
    // request side
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    // answer side
    input wire logic [31:0] hrdata,
    input wire logic hreadyout
);
    // idle bus from time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // one single word transfer, held until the slave takes it
    task automatic xfer(input logic wr, input logic [7:0] off, input logic [31:0] d,
                        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        // upper address bits zero, low byte is the offset
        haddr <= {24'h00_0000, off};
        hwrite <= wr;
        hsize <= 3'h2;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
    endtask : xfer
endmodule : smau_master

`default_nettype wire

// file: tb/smau_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "smau_map.svh"

module smau_top_tb;
    logic hclk, hresetn, hsel, hwrite, hreadyout, ovf, hresp;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int failures, compares;
    logic signed [63:0] e_acc;
    logic [31:0] e_res;
    logic e_q;
    logic [3:0] e_nz;
    logic [31:0] va [3] = '{32'h1234_8765, 32'h8000_8000, 32'h7FFF_FFFF};
    logic [31:0] vb [3] = '{32'hFEDC_0BA9, 32'h8000_8000, 32'h8000_0001};
    logic [31:0] vc [3] = '{32'h0F0F_F0F0, 32'h7FFF_FFFF, 32'h7FFF_0000};
    logic [63:0] vacc [3] = '{64'h0123_4567_89AB_CDEF, 64'h7FFF_FFFF_FFFF_FFFF,
                              64'h8000_0000_0000_0000};

    smau_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .overflow_sticky(ovf));

    smau_master mst (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout));

    // 125 MHz clock
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    task automatic wr(input logic [7:0] off, input logic [31:0] v);
        logic [31:0] nul;
        mst.xfer(1'b1, off, v, nul);
    endtask : wr

    task automatic rd(input logic [7:0] off, output logic [31:0] v);
        mst.xfer(1'b0, off, 32'h0, v);
    endtask : rd

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // bottom or top half, sign extended
    function automatic logic signed [31:0] hw(input logic [31:0] v, input logic top);
        return top ? $signed(v[31:16]) : $signed(v[15:0]);
    endfunction : hw

    // reference result of one command
    task automatic model(input logic [7:0] cmd, input logic [31:0] a, b, c);
        logic [31:0] bx;
        logic signed [63:0] pb, pt, p;
        logic signed [32:0] s;
        bx = cmd[6] ? {b[15:0], b[31:16]} : b;
        pb = hw(a, 1'b0) * hw(bx, 1'b0);
        pt = hw(a, 1'b1) * hw(bx, 1'b1);
        p = $signed(a) * $signed(b) + (cmd[7] ? 64'sh8000_0000 : 64'sh0);
        case (cmd[3:0])
            4'h0: e_acc = e_acc + $signed(a) * $signed(b);
            4'h1: e_acc = e_acc + hw(a, cmd[4]) * hw(b, cmd[5]);
            4'h2: e_acc = e_acc + pb + pt;
            4'h3, 4'h8: begin
                s = (cmd[3:0] == 4'h3) ? pb - pt + $signed(c) : pb + pt;
                e_res = s[31:0];
                e_q = e_q | (s[32] ^ s[31]);
            end
            4'h4: e_acc = e_acc + pb - pt;
            4'h5: e_res = p[63:32] + c;
            4'h6: e_res = c - p[63:32];
            4'h7: e_res = p[63:32];
            4'h9: e_res = pb - pt;
            4'hA: e_res = hw(a, cmd[4]) * hw(b, cmd[5]);
            4'hB: begin
                p = $signed(a) * hw(b, cmd[5]);
                e_res = p[47:16];
            end
            default: ;
        endcase
    endtask : model

    task automatic final_report();
        if (failures == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    // watchdog
    initial begin
        repeat (60000) @(posedge hclk);
        failures++;
        final_report();
    end

    initial begin
        hresetn = 1'b0;
        failures = 0;
        compares = 0;
        e_res = 32'h0;
        e_q = 1'b0;
        e_nz = 4'h5;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        // reset words, then refused writes
        for (int i = 0; i < 8; i++) begin
            rd(8'(i * 4), d);
            chk("reset word", 32'h0, d);
        end
        wr(`SMAU_OFF_NONE, 32'hFFFF_FFFF);
        wr(`SMAU_OFF_RES, 32'h1234_5678);
        rd(`SMAU_OFF_NONE, d);
        chk("unmapped", 32'h0, d);
        chk("response", 32'h0, {31'h0, hresp});
        rd(`SMAU_OFF_RES, d);
        chk("result ro", 32'h0, d);
        // every command byte over three operand sets
        for (int v = 0; v < 3; v++) begin
            wr(`SMAU_OFF_STAT, {e_nz, 28'h0});
            e_q = 1'b0;
            for (int k = 0; k < 256; k++) begin
                e_acc = vacc[v];
                wr(`SMAU_OFF_OPA, va[v]);
                wr(`SMAU_OFF_OPB, vb[v]);
                wr(`SMAU_OFF_OPC, vc[v]);
                wr(`SMAU_OFF_ACCLO, e_acc[31:0]);
                wr(`SMAU_OFF_ACCHI, e_acc[63:32]);
                wr(`SMAU_OFF_CMD, {24'h0, k[7:0]});
                model(k[7:0], va[v], vb[v], vc[v]);
                rd(`SMAU_OFF_RES, d);
                chk("result", e_res, d);
                chk("result", e_res, d);
                rd(`SMAU_OFF_ACCLO, d);
                chk("acc low", e_acc[31:0], d);
                rd(`SMAU_OFF_ACCHI, d);
                chk("acc high", e_acc[63:32], d);
                rd(`SMAU_OFF_STAT, d);
                chk("status", {e_nz, 27'h0, e_q}, d & 32'hF000_0001);
                chk("sticky pin", {31'h0, e_q}, {31'h0, ovf});
            end
        end
        final_report();
    end
endmodule : smau_top_tb

`default_nettype wire
